// ==== inc/ahs_if.sv ====
/*
  Object link between the fieldbus controller and the homing sequencer.
  Assumes both ends share clk; every object is a level held by its writer.
*/
`timescale 1ns/10ps
`default_nettype none

interface ahs_if;
  logic [7:0]  mode_of_op;
  logic [15:0] controlword;
  logic [7:0]  home_method;
  logic [31:0] home_offset;
  logic [31:0] switch_speed;
  logic [31:0] zero_speed;
  logic [31:0] home_accel;
  logic [15:0] block_current;
  logic [15:0] block_period_ms;
  logic [15:0] statusword;

  modport device (input mode_of_op, controlword, home_method, home_offset, switch_speed,
                  zero_speed, home_accel, block_current, block_period_ms,
                  output statusword);
  modport host (output mode_of_op, controlword, home_method, home_offset, switch_speed,
                zero_speed, home_accel, block_current, block_period_ms,
                input statusword);
endinterface

`default_nettype wire

// ==== inc/ahs_pkg.sv ====
/*
  Shared constants, types and the homing-method decoder for the axis homing
  sequencer. Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none

package ahs_pkg;

  localparam logic [7:0] MODE_HOMING      = 8'h06;
  localparam int         CW_START_BIT     = 4;
  localparam int         SW_ERR_BIT       = 13;
  localparam int         SW_HOMED_BIT     = 12;
  localparam int         SW_TGT_BIT       = 10;
  localparam int         CLK_PERIOD_NS    = 100;
  localparam int         MS_NS            = 1000000;
  localparam int         CYC_PER_MS       = MS_NS / CLK_PERIOD_NS;
  localparam logic [7:0] METHOD_RESET     = 8'h23;
  localparam logic [15:0] CW_RESET        = 16'h0000;
  localparam logic [15:0] SW_RESET        = 16'h0400;

  typedef enum logic [1:0] {REF_LIMIT, REF_HOME, REF_INDEX, REF_HERE} ahs_ref_e;

  typedef struct packed {
    logic     valid;
    ahs_ref_e kind;
    logic     use_index;
    logic     on_block;
    logic     dir_pos;
    logic     right_edge;
  } ahs_meth_s;

  // Block methods keep the travel profile of their positive twin.
  function automatic ahs_meth_s ahs_decode(input logic signed [7:0] m);
    ahs_meth_s  r;
    logic [7:0] a;
    logic [7:0] b;
    r          = '0;
    a          = m[7] ? 8'(-m) : 8'(m);
    b          = (a >= 8'h11 && a <= 8'h1E) ? 8'(a - 8'h10) : a;
    r.on_block = m[7];
    r.use_index = (a <= 8'h0E) || (a == 8'h21) || (a == 8'h22);
    r.right_edge = (b == 8'h05) || (b == 8'h06) || (b == 8'h09) || (b == 8'h0A) ||
                   (b == 8'h0D) || (b == 8'h0E);
    if (b == 8'h01 || b == 8'h02) begin
      r.valid   = 1'b1;
      r.kind    = REF_LIMIT;
      r.dir_pos = (b == 8'h02);
    end else if (b >= 8'h03 && b <= 8'h0E) begin
      r.valid   = !(m[7] && b <= 8'h06);
      r.kind    = REF_HOME;
      r.dir_pos = (b >= 8'h07) ? (b <= 8'h0A) : b[0];
    end else if (a == 8'h21 || a == 8'h22) begin
      r.valid   = !m[7];
      r.kind    = REF_INDEX;
      r.dir_pos = (a == 8'h22);
    end else if (a == 8'h23) begin
      r.valid   = !m[7];
      r.kind    = REF_HERE;
    end
    if (a == 8'h00 || a > 8'h23 || (a > 8'h0E && a < 8'h11) || (a > 8'h1E && a < 8'h21)) begin
      r.valid = 1'b0;
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// ==== rtl/ahs_blk_timer.sv ====
/*
  Millisecond timer for the run against a mechanical block.
  Assumes run is held high for the whole wait; dropping it clears the count.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_blk_timer
  import ahs_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        run,
  input  wire logic [15:0] period_ms,
  output logic             expired
);
  typedef struct packed {
    logic [31:0] cyc;
    logic [15:0] ms;
    logic        exp;
  } ahs_tmr_s;

  ahs_tmr_s s_reg;
  ahs_tmr_s s_next;

  always_comb begin
    s_next = s_reg;
    if (!run) begin
      s_next = '0;
    end else if (s_reg.ms >= period_ms) begin
      s_next.exp = 1'b1;
    end else if (s_reg.cyc == 32'(CYCLES_PER_MS - 1)) begin
      s_next.cyc = '0;
      s_next.ms  = 16'(s_reg.ms + 16'h0001);
    end else begin
      s_next.cyc = 32'(s_reg.cyc + 32'h0000_0001);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.exp;
endmodule

`default_nettype wire

// ==== rtl/ahs_device.sv ====
/*
  Homing sequencer of one axis: decodes the homing method, drives the search
  moves, loads the home offset and reports progress in the statusword.
  Assumes switch, index and current inputs are synchronous to clk and that the
  motion stage outside follows vel_cmd with acc_cmd and reports standstill.
*/
// Contract
// - Mode value 6 selects homing.
// - Controlword bit 4 starts; clearing it aborts.
// - Bits 13,12,10 encode homing progress.
// - Error sets bit 13; bit 10 shows standstill.
// - Bit 12 set after completion, cleared otherwise.
// - Index for 1-14, 33, 34; not 17-30.
// - Negative method homes against a current block.
// - Accept only listed negative block methods.
// - Block on current; keep pushing set milliseconds.
// - Block homing only in closed loop.
// - Methods 1, 2: limit switch then index.
// - Methods 3, 4: left home edge, index.
// - Methods 5, 6: right home edge, index.
// - Methods 7-14: home switch with limit watch.
// - Methods 17, 18: limit switch, no index.
// - Methods 19-22: home edge, no index.
// - Methods 23-30: home switch, no index.
// - Methods 33, 34: next index pulse only.
// - Method 35: here, no enable needed.
// - Switch speed, zero speed, homing acceleration.
// - Host enables switch inputs, keeps travel unblocked.
// - Home offset is the found reference position.
`timescale 1ns/10ps
`default_nettype none

module ahs_device
  import ahs_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        reset,
  ahs_if.device            bus,
  input  wire logic        index_pulse,
  input  wire logic        home_sw,
  input  wire logic        limit_pos,
  input  wire logic        limit_neg,
  input  wire logic [15:0] motor_current,
  input  wire logic        closed_loop,
  input  wire logic        op_enabled,
  input  wire logic        standstill,
  output logic [31:0]      vel_cmd,
  output logic [31:0]      acc_cmd,
  output logic             drive_en,
  output logic             pos_load,
  output logic [31:0]      pos_load_val
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SEEK, ST_BLOCK, ST_CLEAR, ST_EDGE, ST_INDEX, ST_STOP, ST_DONE, ST_FAIL
  } ahs_st_e;

  typedef struct packed {
    ahs_st_e     st;
    ahs_meth_s   meth;
    logic        dir;
    logic        homed;
    logic        start_d;
    logic        run_blk;
    logic [15:0] sw;
    logic [31:0] vel;
    logic [31:0] acc;
    logic        drive;
    logic        load;
    logic [31:0] load_val;
  } ahs_dev_s;

  ahs_dev_s  s_reg;
  ahs_dev_s  s_next;
  ahs_meth_s dec;
  logic      start_lvl;
  logic      blk_done;
  logic      hit_end;
  logic      busy;

  ahs_blk_timer #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_blk_timer (
    .clk       (clk),
    .reset     (reset),
    .run       (s_reg.run_blk),
    .period_ms (bus.block_period_ms),
    .expired   (blk_done)
  );

  function automatic logic [31:0] signed_speed(input logic d, input logic [31:0] spd);
    return d ? spd : 32'(-spd);
  endfunction

  always_comb begin
    dec       = ahs_decode(bus.home_method);
    start_lvl = (bus.mode_of_op == MODE_HOMING) && bus.controlword[CW_START_BIT];
    // A block replaces the limit switch; current above threshold marks it.
    hit_end   = s_reg.meth.on_block ? (motor_current > bus.block_current)
                                    : (s_reg.dir ? limit_pos : limit_neg);
    busy      = !(s_reg.st inside {ST_IDLE, ST_DONE, ST_FAIL});
  end

  always_comb begin
    s_next         = s_reg;
    s_next.start_d = start_lvl;
    s_next.load    = 1'b0;
    s_next.acc     = bus.home_accel;
    unique case (s_reg.st)
      ST_IDLE, ST_DONE, ST_FAIL: begin
        if (start_lvl && !s_reg.start_d) begin
          s_next.meth = dec;
          s_next.dir  = dec.dir_pos;
          s_next.vel  = '0;
          if (!dec.valid || (dec.on_block && !closed_loop)) begin
            s_next.st    = ST_FAIL;
            s_next.homed = 1'b0;
          end else if (dec.kind == REF_HERE) begin
            s_next.homed = 1'b0;
            s_next.st    = ST_STOP;
          end else if (op_enabled) begin
            s_next.homed = 1'b0;
            s_next.drive = 1'b1;
            s_next.st    = (dec.kind == REF_INDEX) ? ST_INDEX : ST_SEEK;
          end
        end else if (standstill) begin
          // An interrupted or failed run keeps the drive on until the axis is at rest.
          s_next.drive = 1'b0;
        end
      end
      ST_SEEK: begin
        s_next.vel = signed_speed(s_reg.dir, bus.switch_speed);
        if (s_reg.meth.kind == REF_HOME && home_sw) begin
          // Leave the switch on the side of the wanted edge, then creep back.
          s_next.dir = s_reg.meth.right_edge;
          s_next.st  = ST_CLEAR;
        end else if (hit_end) begin
          if (s_reg.meth.on_block) begin
            s_next.st = ST_BLOCK;
          end else if (s_reg.meth.kind == REF_HOME) begin
            s_next.dir = !s_reg.dir;
          end else begin
            s_next.dir = !s_reg.dir;
            s_next.st  = s_reg.meth.use_index ? ST_INDEX : ST_STOP;
          end
        end
      end
      ST_BLOCK: begin
        s_next.run_blk = 1'b1;
        if (blk_done) begin
          s_next.run_blk = 1'b0;
          s_next.dir     = !s_reg.dir;
          if (s_reg.meth.kind == REF_HOME) begin
            s_next.st = ST_SEEK;
          end else begin
            s_next.st = s_reg.meth.use_index ? ST_INDEX : ST_STOP;
          end
        end
      end
      ST_CLEAR: begin
        s_next.vel = signed_speed(s_reg.dir, bus.switch_speed);
        if (!home_sw) begin
          s_next.dir = !s_reg.dir;
          s_next.st  = ST_EDGE;
        end else if (hit_end) begin
          s_next.st = ST_FAIL;
        end
      end
      ST_EDGE: begin
        s_next.vel = signed_speed(s_reg.dir, bus.zero_speed);
        if (home_sw) begin
          s_next.dir = s_reg.meth.right_edge;
          s_next.st  = s_reg.meth.use_index ? ST_INDEX : ST_STOP;
        end else if (hit_end) begin
          s_next.st = ST_FAIL;
        end
      end
      ST_INDEX: begin
        s_next.vel = signed_speed(s_reg.dir, bus.zero_speed);
        if (index_pulse) begin
          s_next.st = ST_STOP;
        end else if (hit_end && !s_reg.meth.on_block) begin
          s_next.st = ST_FAIL;
        end
      end
      ST_STOP: begin
        s_next.vel = '0;
        if (standstill || s_reg.meth.kind == REF_HERE) begin
          // The offset is loaded in the same cycle that the statusword claims completion.
          s_next.load     = 1'b1;
          s_next.load_val = bus.home_offset;
          s_next.drive    = 1'b0;
          s_next.homed    = 1'b1;
          s_next.st       = ST_DONE;
        end
      end
      default: s_next.st = ST_FAIL;
    endcase
    if (busy && !start_lvl) begin
      // Withdrawing the start bit interrupts the run; the axis brakes to rest.
      s_next.vel     = '0;
      s_next.run_blk = 1'b0;
      s_next.drive   = !standstill && s_reg.drive;
      s_next.st      = ST_IDLE;
    end
    if (s_next.st == ST_FAIL) begin
      s_next.vel     = '0;
      s_next.run_blk = 1'b0;
      s_next.homed   = 1'b0;
    end
    s_next.sw = '0;
    s_next.sw[SW_ERR_BIT]   = (s_next.st == ST_FAIL);
    s_next.sw[SW_HOMED_BIT] = s_next.homed && (s_next.st != ST_FAIL);
    unique case (s_next.st)
      ST_FAIL: s_next.sw[SW_TGT_BIT] = standstill;
      ST_IDLE: s_next.sw[SW_TGT_BIT] = !s_next.homed;
      ST_DONE: s_next.sw[SW_TGT_BIT] = 1'b1;
      default: s_next.sw[SW_TGT_BIT] = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg         <= '0;
      s_reg.st      <= ST_IDLE;
      s_reg.sw      <= SW_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.statusword = s_reg.sw;
  assign vel_cmd        = s_reg.vel;
  assign acc_cmd        = s_reg.acc;
  assign drive_en       = s_reg.drive;
  assign pos_load       = s_reg.load;
  assign pos_load_val   = s_reg.load_val;
endmodule

`default_nettype wire

// ==== rtl/ahs_host.sv ====
/*
  Fieldbus-controller end: holds the homing objects, starts and stops homing
  and decodes the statusword for its user. Assumes the user has enabled the
  switch inputs and left travel past the limit switch unblocked.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_host
  import ahs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  ahs_if.host              bus,
  input  wire logic        cfg_load,
  input  wire logic [7:0]  cfg_method,
  input  wire logic [31:0] cfg_offset,
  input  wire logic [31:0] cfg_switch_speed,
  input  wire logic [31:0] cfg_zero_speed,
  input  wire logic [31:0] cfg_accel,
  input  wire logic [15:0] cfg_block_current,
  input  wire logic [15:0] cfg_block_ms,
  input  wire logic        go,
  input  wire logic        halt,
  output logic             busy,
  output logic             done,
  output logic             failed,
  output logic             homed
);
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] cw;
    logic [7:0]  meth;
    logic [31:0] offs;
    logic [31:0] sspd;
    logic [31:0] zspd;
    logic [31:0] acc;
    logic [15:0] bcur;
    logic [15:0] bms;
    logic [3:0]  flags;
  } ahs_host_s;

  ahs_host_s s_reg;
  ahs_host_s s_next;

  always_comb begin
    s_next = s_reg;
    if (cfg_load) begin
      s_next.meth = cfg_method;
      s_next.offs = cfg_offset;
      s_next.sspd = cfg_switch_speed;
      s_next.zspd = cfg_zero_speed;
      s_next.acc  = cfg_accel;
      s_next.bcur = cfg_block_current;
      s_next.bms  = cfg_block_ms;
    end
    if (halt) begin
      s_next.cw[CW_START_BIT] = 1'b0;
    end else if (go) begin
      s_next.mode             = MODE_HOMING;
      // A start needs a rising edge, so a repeated go first drops the bit.
      s_next.cw[CW_START_BIT] = !s_reg.cw[CW_START_BIT];
    end else if (s_reg.mode == MODE_HOMING) begin
      s_next.cw[CW_START_BIT] = s_reg.cw[CW_START_BIT] | s_reg.flags[0];
    end
    s_next.flags[0] = go && !halt && s_reg.cw[CW_START_BIT];
    s_next.flags[1] = bus.statusword[SW_ERR_BIT];
    s_next.flags[2] = !bus.statusword[SW_ERR_BIT] && bus.statusword[SW_HOMED_BIT] &&
                      bus.statusword[SW_TGT_BIT];
    s_next.flags[3] = bus.statusword[SW_HOMED_BIT];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg      <= '0;
      s_reg.meth <= METHOD_RESET;
      s_reg.cw   <= CW_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.mode_of_op      = s_reg.mode;
  assign bus.controlword     = s_reg.cw;
  assign bus.home_method     = s_reg.meth;
  assign bus.home_offset     = s_reg.offs;
  assign bus.switch_speed    = s_reg.sspd;
  assign bus.zero_speed      = s_reg.zspd;
  assign bus.home_accel      = s_reg.acc;
  assign bus.block_current   = s_reg.bcur;
  assign bus.block_period_ms = s_reg.bms;
  assign busy   = s_reg.cw[CW_START_BIT];
  assign failed = s_reg.flags[1];
  assign done   = s_reg.flags[2];
  assign homed  = s_reg.flags[3];
endmodule

`default_nettype wire

// ==== tb/ahs_link_assertions.sv ====
/*
  Concurrent checks on the object link between host and device ends.
  Assumes both ends share clk and the asynchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module ahs_link_assertions
  import ahs_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  mode_of_op,
  input wire logic [15:0] controlword,
  input wire logic [15:0] statusword
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_start;
    $rose(mode_of_op == MODE_HOMING && controlword[CW_START_BIT]);
  endsequence
  sequence s_running;
    statusword == 16'h0000;
  endsequence

  property p_spare_bits;
    (statusword & 16'hCBFF) == 16'h0000;
  endproperty
  a_spare_bits: assert property (p_spare_bits) else $error("statusword spare bits set");
  property p_start_clears;
    s_start |-> ##[1:3] !statusword[SW_HOMED_BIT];
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("homed bit kept in run");
  property p_abort;
    $fell(controlword[CW_START_BIT]) and s_running |=> statusword == 16'h0400;
  endproperty
  a_abort: assert property (p_abort) else $error("abort not reported");
  property p_run_mode;
    s_running |-> $past(mode_of_op) == MODE_HOMING && $past(controlword[CW_START_BIT]);
  endproperty
  a_run_mode: assert property (p_run_mode) else $error("run without mode or start");
  property p_err_homed;
    statusword[SW_ERR_BIT] |-> !statusword[SW_HOMED_BIT];
  endproperty
  a_err_homed: assert property (p_err_homed) else $error("error with homed bit");
  property p_fell_homed;
    $fell(statusword[SW_HOMED_BIT]) |-> statusword[SW_ERR_BIT] || statusword == 16'h0000;
  endproperty
  a_fell_homed: assert property (p_fell_homed) else $error("homed bit lost outside run");
  property p_rose_homed;
    $rose(statusword[SW_HOMED_BIT]) |->
      $past(statusword) == 16'h0000 && statusword == 16'h1400 && $past(controlword[CW_START_BIT]);
  endproperty
  a_rose_homed: assert property (p_rose_homed) else $error("homed without finished run");
  property p_err_hold;
    statusword[SW_ERR_BIT] && $stable(controlword) && $stable(mode_of_op) |=> statusword[SW_ERR_BIT];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error status dropped");
  c_run: cover property (s_start ##[1:3] s_running);
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
/*
  Bench: host and device ends joined by the link; a slow axis with limit
  switches, home switch, index marks every 16 steps and end blocks closes
  the loop. Assumes the link contract of the two ends.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import ahs_pkg::*;
  localparam int FAIL = 9999;
  localparam int ABORT = 8888;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cfg_load = 1'b0, go = 1'b0, halt = 1'b0;
  logic        closed_loop = 1'b1, op_enabled = 1'b1, on_blk = 1'b0;
  logic [7:0]  cfg_method = 8'h00;
  logic [31:0] cfg_offset = 32'h0, sw_spd = 32'h0, zr_spd = 32'h0, accel = 32'h0;
  logic        busy, done, failed, homed, drive_en, pos_load;
  logic [31:0] vel_cmd, acc_cmd, pos_load_val;
  int          pos = 5, tick = 0, err_count = 0, cmp_count = 0;
  // The block stops the axis, so pushing into it is what raises the current.
  wire logic   push = on_blk && ((pos <= -100 && $signed(vel_cmd) < 0) ||
                                 (pos >= 100 && $signed(vel_cmd) > 0));
  wire logic [15:0] cur = push ? 16'h0200 : 16'h0000;
  int tm[22] = '{35, 34, 15, 33, 1, 253, 17, 2, 18, 3, 5, 19, 255, 21, 7, 10, 26, 14, 255, 239,
                 34, 35};
  int te[22] = '{5, 16, FAIL, 0, -96, FAIL, -100, 96, 100, 16, 48, 20, FAIL, 40, 16, 48, 40, 48,
                 -96, -100, ABORT, 5};
  int tv[22] = '{0, 2, 0, -2, -1, 0, -1, 1, 1, 1, 1, 1, 0, 1, 1, 1, 1, -1, -1, -1, 2, 0};

  ahs_if bus ();
  ahs_host u_ahs_host (.clk(clk), .reset(reset), .bus(bus), .cfg_load(cfg_load),
    .cfg_method(cfg_method), .cfg_offset(cfg_offset), .cfg_switch_speed(sw_spd),
    .cfg_zero_speed(zr_spd), .cfg_accel(accel), .cfg_block_current(16'h0100),
    .cfg_block_ms(16'h0002), .go(go), .halt(halt), .busy(busy), .done(done),
    .failed(failed), .homed(homed));
  ahs_device #(.CYCLES_PER_MS(4)) u_ahs_device (.clk(clk), .reset(reset), .bus(bus),
    .index_pulse(pos % 16 == 0), .home_sw(pos >= 20 && pos <= 40),
    .limit_pos(!on_blk && pos >= 100), .limit_neg(!on_blk && pos <= -100),
    .motor_current(cur), .closed_loop(closed_loop), .op_enabled(op_enabled),
    .standstill(vel_cmd == 32'h0), .vel_cmd(vel_cmd), .acc_cmd(acc_cmd),
    .drive_en(drive_en), .pos_load(pos_load), .pos_load_val(pos_load_val));
  ahs_link_assertions u_ahs_link_assertions (.clk(clk), .reset(reset),
    .mode_of_op(bus.mode_of_op), .controlword(bus.controlword), .statusword(bus.statusword));

  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    tick <= (tick + 1) % 8;
    if (cfg_load) begin
      pos <= 5;
    end else if (tick == 7 && vel_cmd != 32'h0 && !push) begin
      pos <= pos + (($signed(vel_cmd) > 0) ? 1 : -1);
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic run(input int m, input int ex, input int vc);
    int          n;
    logic [31:0] first;
    logic [31:0] v0;
    v0 = (vc == 1) ? sw_spd : (vc == -1) ? -sw_spd : (vc == 2) ? zr_spd :
         (vc == -2) ? -zr_spd : 32'h0;
    @(posedge clk);
    on_blk <= m[7];
    op_enabled <= (m != 35);
    closed_loop <= !(m == 255 && ex == FAIL);
    cfg_method <= 8'(m);
    cfg_offset <= $urandom;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    first = 32'h0;
    for (n = 0; n < 5000 && pos_load !== 1'b1 && !(ex == FAIL && failed === 1'b1) &&
         !(ex == ABORT && n == 20); n++) begin
      @(negedge clk);
      if (first === 32'h0) first = vel_cmd;
    end
    if (n == 5000) begin
      err_count++;
      results();
    end
    if (ex == ABORT) begin
      check("drive_run", drive_en, 32'h1);
      check("status_run", bus.statusword, 16'h0000);
      @(posedge clk);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
    end else if (ex != FAIL) begin
      check("ref_pos", pos, ex);
      check("load_val", pos_load_val, cfg_offset);
    end
    repeat (3) @(negedge clk);
    check("first_vel", first, v0);
    check("acc_cmd", acc_cmd, accel);
    check("homed", homed, ex != FAIL && ex != ABORT);
    check("status", bus.statusword, (ex == FAIL) ? 16'h2400 : (ex == ABORT) ? 16'h0400 :
          16'h1400);
    check("done", done, ex != FAIL && ex != ABORT);
    check("busy", busy, ex != ABORT);
    check("drive_en", drive_en, 1'b0);
  endtask

  initial begin
    void'($urandom(4));
    sw_spd = 32'd1000 + $urandom_range(0, 999);
    zr_spd = $urandom_range(1, 999);
    accel = $urandom;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // Fail runs each follow a success so a stale failed flag cannot end them early.
    for (int i = 0; i < 22; i++) begin
      run(tm[i], te[i], tv[i]);
    end
    results();
  end
endmodule

`default_nettype wire
